// ### hdl/gtan_regs.sv
// Purpose: Management register set for gigabit twisted-pair auto-negotiation
// Assumes: mdc and mdio_i synchronous to clk_sys; management clock well below 25 MHz
// Notes:   Registers 0, 1 and 6 mirror the views given by the control logic outside
`timescale 1ns/1ps
`include "gtan_defines.svh"

module gtan_regs (
	input  wire logic        clk_sys,
	input  wire logic        rstn,
	input  wire logic        mdc,
	input  wire logic        mdio_i,
	output logic             mdio_o,
	output logic             mdio_oe,
	input  wire logic [4:0]  phy_addr_strap,
	input  wire logic [15:0] ctrl_view,
	input  wire logic [15:0] stat_view,
	input  wire logic [15:0] exp_view,
	input  wire logic        page_rx_valid,
	input  wire logic        page_rx_next,
	input  wire logic [15:0] page_rx_word,
	input  wire logic        role_master,
	output logic [15:0]      adv_word,
	output logic [15:0]      np_tx_word,
	output logic [15:0]      partner_base_word,
	output logic [15:0]      partner_np_word,
	output logic [2:0]       test_mode,
	output logic             manual_role_en,
	output logic             manual_role_master,
	output logic             port_multi,
	output logic             adv_1000_fd,
	output logic             adv_1000_hd,
	output logic             role_pref_master,
	output logic             tx_loop_timing
);

	////////////////////////////////////////////////////////////////////////////////
	// State

	gtan_pkg::gtan_state_t st_q;
	gtan_pkg::gtan_state_t st_d;
	logic                  mdc_rise;
	logic                  wr_commit;
	logic [15:0]           wr_word;
	logic [12:0]           hdr_word;
	logic                  hdr_ok;

	gtan_mdc_edge u_edge (
		.clk_sys (clk_sys),
		.rstn    (rstn),
		.mdc     (mdc),
		.rise_q  (mdc_rise)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Read view

	function automatic logic [15:0] read_reg(
		input logic [4:0]            addr,
		input gtan_pkg::gtan_state_t s,
		input logic [15:0]           ctrl,
		input logic [15:0]           stat,
		input logic [15:0]           expn
	);
		logic [15:0] v;
		v = 16'h0000;
		case (addr)
			`GTAN_REG_CTRL:  v = ctrl;
			`GTAN_REG_STAT:  v = stat;
			`GTAN_REG_ADV:   v = s.adv;
			`GTAN_REG_PBASE: v = s.partner_base;
			`GTAN_REG_EXP:   v = expn;
			`GTAN_REG_NPTX:  v = s.np_tx;
			`GTAN_REG_PNP:   v = s.partner_np;
			`GTAN_REG_GIG:   v = s.gig;
			default:         v = 16'h0000;
		endcase
		return v;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Frame decode and register update

	assign hdr_word  = {st_q.shift[11:0], mdio_i};
	assign hdr_ok    = hdr_word[12] && (hdr_word[9:5] == st_q.phy_addr) &&
	                   ((hdr_word[11:10] == `GTAN_OP_READ) ||
	                    (hdr_word[11:10] == `GTAN_OP_WRITE));
	assign wr_word   = {st_q.shift[14:0], mdio_i};
	assign wr_commit = mdc_rise && (st_q.frame == gtan_pkg::GTAN_WDAT) &&
	                   (st_q.bit_cnt == `GTAN_DATA_LAST);

	always_comb begin
		st_d = st_q;

		// Address strap is caught once after reset release, never under reset
		if (!st_q.strap_done) begin
			st_d.phy_addr   = phy_addr_strap;
			st_d.strap_done = 1'b1;
		end

		if (mdc_rise) begin
			case (st_q.frame)
				gtan_pkg::GTAN_PRE: begin
					if (mdio_i) begin
						if (st_q.pre_cnt != `GTAN_PRE_MIN) begin
							st_d.pre_cnt = st_q.pre_cnt + 6'h01;
						end
					end else if (st_q.pre_cnt == `GTAN_PRE_MIN) begin
						st_d.frame   = gtan_pkg::GTAN_HDR;
						st_d.bit_cnt = 5'h00;
						st_d.shift   = 16'h0000;
					end else begin
						st_d.pre_cnt = 6'h00;
					end
				end
				gtan_pkg::GTAN_HDR: begin
					st_d.shift   = {st_q.shift[14:0], mdio_i};
					st_d.bit_cnt = st_q.bit_cnt + 5'h01;
					if (st_q.bit_cnt == `GTAN_HDR_LAST) begin
						st_d.bit_cnt  = 5'h00;
						st_d.pre_cnt  = 6'h00;
						st_d.reg_addr = hdr_word[4:0];
						st_d.rd_word  = read_reg(hdr_word[4:0], st_q, ctrl_view,
						                         stat_view, exp_view);
						// Foreign address or bad opcode: stay silent, wait for preamble
						if (!hdr_ok) begin
							st_d.frame = gtan_pkg::GTAN_PRE;
						end else if (hdr_word[11:10] == `GTAN_OP_READ) begin
							st_d.frame = gtan_pkg::GTAN_TA;
							st_d.shift = 16'h0001;
						end else begin
							st_d.frame = gtan_pkg::GTAN_TA;
							st_d.shift = 16'h0000;
						end
					end
				end
				gtan_pkg::GTAN_TA: begin
					// Read: first turnaround bit is released, second is driven low
					if (st_q.shift[0]) begin
						st_d.mdio_oe = 1'b1;
						st_d.mdio_o  = 1'b0;
						st_d.frame   = gtan_pkg::GTAN_RDAT;
						st_d.bit_cnt = 5'h00;
					end else if (st_q.bit_cnt == `GTAN_TA_LAST) begin
						st_d.frame   = gtan_pkg::GTAN_WDAT;
						st_d.bit_cnt = 5'h00;
					end else begin
						st_d.bit_cnt = st_q.bit_cnt + 5'h01;
					end
				end
				gtan_pkg::GTAN_WDAT: begin
					st_d.shift   = wr_word;
					st_d.bit_cnt = st_q.bit_cnt + 5'h01;
					if (st_q.bit_cnt == `GTAN_DATA_LAST) begin
						st_d.frame   = gtan_pkg::GTAN_PRE;
						st_d.bit_cnt = 5'h00;
					end
				end
				gtan_pkg::GTAN_RDAT: begin
					if (st_q.bit_cnt == `GTAN_DATA_BITS) begin
						st_d.mdio_oe = 1'b0;
						st_d.mdio_o  = 1'b0;
						st_d.frame   = gtan_pkg::GTAN_PRE;
						st_d.bit_cnt = 5'h00;
					end else begin
						st_d.mdio_o  = st_q.rd_word[15];
						st_d.rd_word = {st_q.rd_word[14:0], 1'b0};
						st_d.bit_cnt = st_q.bit_cnt + 5'h01;
					end
				end
				default: begin
					st_d.frame   = gtan_pkg::GTAN_PRE;
					st_d.mdio_oe = 1'b0;
				end
			endcase
		end

		if (wr_commit) begin
			case (st_q.reg_addr)
				`GTAN_REG_ADV: begin
					// Next page bit and selector stay fixed; ability field writable
					st_d.adv = {1'b1, wr_word[14:5], `GTAN_SELECTOR};
				end
				`GTAN_REG_NPTX: begin
					st_d.np_tx = wr_word;
				end
				`GTAN_REG_GIG: begin
					// Low byte is stored as written; software keeps it zero
					st_d.gig = wr_word;
				end
				default: begin
					st_d.np_tx = st_q.np_tx;
				end
			endcase
		end

		// Link pages from the arbitration logic; next pages never reach register 5
		if (page_rx_valid) begin
			if (page_rx_next) begin
				st_d.partner_np = page_rx_word;
			end else begin
				st_d.partner_base = page_rx_word;
			end
		end

		// Forced role wins over port type preference
		st_d.pref_master = st_d.gig[`GTAN_GIG_MAN_EN] ? st_d.gig[`GTAN_GIG_MAN_VAL]
		                                                : st_d.gig[`GTAN_GIG_PORT];
		// Slave loops back recovered clock; master uses the local source
		st_d.tx_loop = ~role_master;
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			st_q              <= '0;
			st_q.frame        <= gtan_pkg::GTAN_PRE;
			st_q.adv          <= {1'b1, `GTAN_ADV_HI_RST, `GTAN_TECH_RST, `GTAN_SELECTOR};
			st_q.np_tx        <= `GTAN_NPTX_RST;
			st_q.gig          <= `GTAN_GIG_RST;
			st_q.tx_loop      <= 1'b1;
		end else begin
			st_q <= st_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs

	assign mdio_o             = st_q.mdio_o;
	assign mdio_oe            = st_q.mdio_oe;
	assign adv_word           = st_q.adv;
	assign np_tx_word         = st_q.np_tx;
	assign partner_base_word  = st_q.partner_base;
	assign partner_np_word    = st_q.partner_np;
	assign test_mode          = st_q.gig[`GTAN_GIG_TM_HI:`GTAN_GIG_TM_LO];
	assign manual_role_en     = st_q.gig[`GTAN_GIG_MAN_EN];
	assign manual_role_master = st_q.gig[`GTAN_GIG_MAN_VAL];
	assign port_multi         = st_q.gig[`GTAN_GIG_PORT];
	assign adv_1000_fd        = st_q.gig[`GTAN_GIG_FD];
	assign adv_1000_hd        = st_q.gig[`GTAN_GIG_HD];
	assign role_pref_master   = st_q.pref_master;
	assign tx_loop_timing     = st_q.tx_loop;

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rstn);

	a_adv_fixed_fields:
	assert property (adv_word[4:0] == `GTAN_SELECTOR && adv_word[15] == 1'b1)
		else $error("advertisement fixed fields altered");

	a_adv_tech_write:
	assert property (wr_commit && st_q.reg_addr == `GTAN_REG_ADV && !page_rx_valid
	                 |=> adv_word[12:5] == $past(wr_word[12:5]))
		else $error("technology field not written");

	a_loop_timing:
	assert property (##1 tx_loop_timing == !$past(role_master))
		else $error("transmit timing not following role");

	a_base_kept:
	assert property (page_rx_valid && page_rx_next
	                 |=> $stable(partner_base_word) && partner_np_word == $past(page_rx_word))
		else $error("next page touched base ability");

	a_test_mode_wr:
	assert property (wr_commit && st_q.reg_addr == `GTAN_REG_GIG
	                 |=> test_mode == $past(wr_word[15:13]) && adv_1000_hd == $past(wr_word[8]))
		else $error("test mode write lost");

	a_role_pref:
	assert property (!manual_role_en |-> role_pref_master == port_multi)
		else $error("preference ignores port type");

	a_forced_role:
	assert property (manual_role_en |-> role_pref_master == manual_role_master)
		else $error("forced role not applied");

	a_ro_write:
	assert property (wr_commit && st_q.reg_addr == `GTAN_REG_PBASE && !page_rx_valid
	                 |=> $stable(partner_base_word) && $stable(st_q.gig) && $stable(adv_word))
		else $error("read-only write had effect");

	a_read_turn:
	assert property ($rose(mdio_oe) |-> !mdio_o ##1 mdio_oe [*1])
		else $error("turnaround drive wrong");

	a_fd_write:
	assert property (wr_commit && st_q.reg_addr == `GTAN_REG_GIG
	                 |=> adv_1000_fd == $past(wr_word[9]) && manual_role_en == $past(wr_word[12]))
		else $error("full duplex bit not written");

	a_np_exchange:
	assert property (adv_word[`GTAN_ADV_NP_BIT] == 1'b1)
		else $error("next page bit cleared");

	a_test_mode_reset:
	assert property (!st_q.strap_done |-> test_mode == 3'h0)
		else $error("test mode not zero after reset");

	a_manual_en_reset:
	assert property (!st_q.strap_done |-> !manual_role_en)
		else $error("manual role enable not zero after reset");

	a_role_val_reset:
	assert property (!st_q.strap_done |-> !manual_role_master)
		else $error("forced role value not zero after reset");

	a_master_timing:
	assert property (role_master |=> !tx_loop_timing)
		else $error("master not on local timing");

	a_duplex_hold:
	assert property (!wr_commit |=> $stable(adv_1000_fd) && $stable(adv_1000_hd))
		else $error("duplex advertisement changed without a write");

	a_np_rx_kept:
	assert property (wr_commit && st_q.reg_addr == `GTAN_REG_PNP && !page_rx_valid
	                 |=> $stable(partner_np_word))
		else $error("write reached partner next page");

	a_view_write:
	assert property (wr_commit && st_q.reg_addr != `GTAN_REG_ADV &&
	                 st_q.reg_addr != `GTAN_REG_NPTX && st_q.reg_addr != `GTAN_REG_GIG
	                 |=> $stable(adv_word) && $stable(np_tx_word) && $stable(st_q.gig))
		else $error("read-only write changed writable state");

endmodule

// ### hdl/gtan_defines.svh
// Purpose: Offsets, field positions, reset values and frame counts of the
//          gigabit twisted-pair negotiation register set
// Assumes: Register addresses are the 5-bit management register numbers
// Notes:   Values without a fixed figure are plain defaults
`ifndef GTAN_DEFINES_SVH
`define GTAN_DEFINES_SVH

`define GTAN_REG_CTRL      5'h00
`define GTAN_REG_STAT      5'h01
`define GTAN_REG_ADV       5'h04
`define GTAN_REG_PBASE     5'h05
`define GTAN_REG_EXP       5'h06
`define GTAN_REG_NPTX      5'h07
`define GTAN_REG_PNP       5'h08
`define GTAN_REG_GIG       5'h09

`define GTAN_ADV_NP_BIT    15
`define GTAN_ADV_TECH_HI   12
`define GTAN_ADV_TECH_LO   5
`define GTAN_ADV_SEL_HI    4
`define GTAN_GIG_TM_HI     15
`define GTAN_GIG_TM_LO     13
`define GTAN_GIG_MAN_EN    12
`define GTAN_GIG_MAN_VAL   11
`define GTAN_GIG_PORT      10
`define GTAN_GIG_FD        9
`define GTAN_GIG_HD        8

`define GTAN_SELECTOR      5'h01
`define GTAN_TECH_RST      8'h00
`define GTAN_ADV_HI_RST    2'h0
`define GTAN_NPTX_RST      16'h0000
`define GTAN_GIG_RST       16'h0300

`define GTAN_PRE_MIN       6'h20
`define GTAN_HDR_LAST      5'h0C
`define GTAN_TA_LAST       5'h01
`define GTAN_DATA_LAST     5'h0F
`define GTAN_DATA_BITS     5'h10
`define GTAN_OP_READ       2'h2
`define GTAN_OP_WRITE      2'h1

`endif

// ### hdl/gtan_pkg.sv
// Purpose: Types of the negotiation register set
// Assumes: One-hot frame states
// Notes:   Offsets and counts live in the defines header
package gtan_pkg;

	typedef enum logic [4:0] {
		GTAN_PRE  = 5'h01,
		GTAN_HDR  = 5'h02,
		GTAN_TA   = 5'h04,
		GTAN_WDAT = 5'h08,
		GTAN_RDAT = 5'h10
	} gtan_frame_t;

	typedef struct packed {
		logic prev;
		logic rise;
	} gtan_edge_t;

	typedef struct packed {
		gtan_frame_t frame;
		logic [5:0]  pre_cnt;
		logic [4:0]  bit_cnt;
		logic [15:0] shift;
		logic [4:0]  reg_addr;
		logic [15:0] rd_word;
		logic        mdio_o;
		logic        mdio_oe;
		logic [4:0]  phy_addr;
		logic        strap_done;
		logic [15:0] adv;
		logic [15:0] np_tx;
		logic [15:0] gig;
		logic [15:0] partner_base;
		logic [15:0] partner_np;
		logic        pref_master;
		logic        tx_loop;
	} gtan_state_t;

endpackage

// ### hdl/gtan_mdc_edge.sv
// Purpose: Turns the management clock pin into a one-cycle rising-edge enable
// Assumes: mdc is synchronous to clk_sys and much slower than it
// Notes:   The enable lags the pin edge by one system clock
`timescale 1ns/1ps

module gtan_mdc_edge (
	input  wire logic clk_sys,
	input  wire logic rstn,
	input  wire logic mdc,
	output logic      rise_q
);

	gtan_pkg::gtan_edge_t st_q;
	gtan_pkg::gtan_edge_t st_d;

	always_comb begin
		st_d      = st_q;
		st_d.prev = mdc;
		st_d.rise = mdc & ~st_q.prev;
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign rise_q = st_q.rise;

endmodule

// ### verification/gtan_sta_model.sv
// Purpose: Station management model that runs MDC/MDIO frames into the register set
// Assumes: MDIO carries a pull-up; mdc stands low between frames
// Notes:   Each mdc half lasts four system clocks, well above the two-clock minimum
`timescale 1ns/1ps

module gtan_sta_model (
	clk_sys,
	mdio_w,
	mdc,
	drv,
	drv_oe
);
	input  wire logic clk_sys;
	input  wire logic mdio_w;
	output logic      mdc;
	output logic      drv;
	output logic      drv_oe;

	initial begin
		mdc = 1'b0;
		drv = 1'b1;
		drv_oe = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Reads let go of the line after the register address, so the block can turn it
	task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
		input logic [15:0] wd, output logic [63:0] smp);
		logic [63:0] v;
		v = {32'hFFFFFFFF, 2'b01, op, pa, ra, 2'b10, wd[15:8],
			(ra == 5'h09) ? 8'h00 : wd[7:0]};
		for (int i = 0; i < 64; i++) begin
			@(posedge clk_sys);
			mdc <= 1'b0;
			drv <= v[63 - i];
			drv_oe <= (op == 2'h1) || (i < 46);
			repeat (4) @(posedge clk_sys);
			mdc <= 1'b1;
			repeat (3) @(posedge clk_sys);
			@(negedge clk_sys);
			smp[63 - i] = mdio_w;
		end
		@(posedge clk_sys);
		mdc <= 1'b0;
		drv_oe <= 1'b0;
	endtask
endmodule

// ### verification/gtan_regs_tb_top.sv
// Purpose: Self-checking bench of the negotiation register set
// Assumes: Read data is sampled after the rise that presents it
// Notes:   Views of registers 0, 1 and 6 are held constant
`timescale 1ns/1ps
`include "gtan_defines.svh"

module gtan_regs_tb_top;
	localparam logic [4:0]  PA   = 5'h0B;
	localparam logic [15:0] CTRL = 16'h1140;
	localparam logic [15:0] STAT = 16'h796D;
	localparam logic [15:0] EXPV = 16'h0004;
	localparam logic [4:0]  RA [8] = '{5'h00, 5'h01, 5'h05, 5'h06, 5'h08, 5'h0A, 5'h1F, 5'h04};
	localparam logic [15:0] RE [8] = '{CTRL, STAT, 16'h0000, EXPV, 16'h0000, 16'h0000,
		16'h0000, 16'h8001};
	localparam logic [15:0] GV [5] = '{16'hF800, 16'h1400, 16'h0400, 16'h0A00, 16'h0100};
	localparam logic        GP [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};

	logic        clk_sys, rstn, mdc, drv, drv_oe, mdio_w, mdio_o, mdio_oe;
	logic        page_rx_valid, page_rx_next, role_master;
	logic [15:0] page_rx_word, adv_word, np_tx_word, partner_base_word, partner_np_word;
	logic [2:0]  test_mode;
	logic        manual_role_en, manual_role_master, port_multi, adv_1000_fd, adv_1000_hd;
	logic        role_pref_master, tx_loop_timing;
	logic [63:0] smp;
	int          fail_count, checks, cyc;

	// Pull-up wins whenever nobody drives the line
	assign mdio_w = mdio_oe ? mdio_o : (drv_oe ? drv : 1'b1);

	gtan_sta_model sta (.clk_sys(clk_sys), .mdio_w(mdio_w), .mdc(mdc), .drv(drv),
		.drv_oe(drv_oe));

	gtan_regs dut (.clk_sys(clk_sys), .rstn(rstn), .mdc(mdc), .mdio_i(mdio_w),
		.mdio_o(mdio_o), .mdio_oe(mdio_oe), .phy_addr_strap(PA), .ctrl_view(CTRL),
		.stat_view(STAT), .exp_view(EXPV), .page_rx_valid(page_rx_valid),
		.page_rx_next(page_rx_next), .page_rx_word(page_rx_word), .role_master(role_master),
		.adv_word(adv_word), .np_tx_word(np_tx_word), .partner_base_word(partner_base_word),
		.partner_np_word(partner_np_word), .test_mode(test_mode),
		.manual_role_en(manual_role_en), .manual_role_master(manual_role_master),
		.port_multi(port_multi), .adv_1000_fd(adv_1000_fd), .adv_1000_hd(adv_1000_hd),
		.role_pref_master(role_pref_master), .tx_loop_timing(tx_loop_timing));

	initial clk_sys = 1'b0;
	always #20 clk_sys = ~clk_sys;

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic results();
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic wr(input logic [4:0] ra, input logic [15:0] d);
		sta.frame(`GTAN_OP_WRITE, PA, ra, d, smp);
		@(negedge clk_sys);
	endtask

	// Checks the data, the driven-low turnaround bit and the release after the frame
	task automatic rd(input logic [4:0] ra, input logic [15:0] exp);
		sta.frame(`GTAN_OP_READ, PA, ra, 16'h0000, smp);
		chk(smp[16:1], exp);
		chk({15'h0000, smp[17]}, 16'h0000);
		@(negedge clk_sys);
		chk({15'h0000, mdio_oe}, 16'h0000);
	endtask

	function automatic logic [15:0] gig_out();
		return {test_mode, manual_role_en, manual_role_master, port_multi, adv_1000_fd,
			adv_1000_hd, 8'h00};
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		rd(`GTAN_REG_ADV, 16'h8001);
		rd(`GTAN_REG_NPTX, 16'h0000);
		rd(`GTAN_REG_GIG, 16'h0300);
		chk(gig_out(), 16'h0300);
		chk({15'h0000, role_pref_master}, 16'h0000);
		$display("test reset done");
	endtask

	// Forced role overrides the port type; without force the port type decides
	task automatic t_gig();
		for (int i = 0; i < 5; i++) begin
			wr(`GTAN_REG_GIG, GV[i]);
			rd(`GTAN_REG_GIG, GV[i]);
			chk(gig_out(), GV[i]);
			chk({15'h0000, role_pref_master}, {15'h0000, GP[i]});
		end
		$display("test gigabit control done");
	endtask

	task automatic t_adv();
		wr(`GTAN_REG_ADV, 16'h7FE0);
		rd(`GTAN_REG_ADV, 16'hFFE1);
		chk(adv_word, 16'hFFE1);
		wr(`GTAN_REG_ADV, 16'h001E);
		rd(`GTAN_REG_ADV, 16'h8001);
		wr(`GTAN_REG_NPTX, 16'hA5C3);
		rd(`GTAN_REG_NPTX, 16'hA5C3);
		chk(np_tx_word, 16'hA5C3);
		$display("test advertisement done");
	endtask

	task automatic t_ro();
		for (int i = 0; i < 7; i++) begin
			wr(RA[i], 16'hFFFF);
		end
		for (int i = 0; i < 8; i++) begin
			rd(RA[i], RE[i]);
		end
		rd(`GTAN_REG_GIG, 16'h0100);
		$display("test read-only done");
	endtask

	task automatic t_page();
		@(posedge clk_sys);
		page_rx_word <= 16'h4DE1;
		page_rx_next <= 1'b0;
		page_rx_valid <= 1'b1;
		@(posedge clk_sys);
		page_rx_word <= 16'h2C0F;
		page_rx_next <= 1'b1;
		@(posedge clk_sys);
		page_rx_valid <= 1'b0;
		rd(`GTAN_REG_PBASE, 16'h4DE1);
		rd(`GTAN_REG_PNP, 16'h2C0F);
		chk(partner_base_word, 16'h4DE1);
		chk(partner_np_word, 16'h2C0F);
		$display("test pages done");
	endtask

	task automatic t_role();
		@(posedge clk_sys);
		role_master <= 1'b1;
		@(posedge clk_sys);
		@(negedge clk_sys);
		chk({15'h0000, tx_loop_timing}, 16'h0000);
		@(posedge clk_sys);
		role_master <= 1'b0;
		@(posedge clk_sys);
		@(negedge clk_sys);
		chk({15'h0000, tx_loop_timing}, 16'h0001);
		$display("test timing role done");
	endtask

	// A frame for another address is ignored; the pull-up shows through
	task automatic t_badaddr();
		sta.frame(`GTAN_OP_READ, PA ^ 5'h01, `GTAN_REG_GIG, 16'h0000, smp);
		@(negedge clk_sys);
		chk(smp[16:1], 16'hFFFF);
		chk({15'h0000, smp[17]}, 16'h0001);
		chk({15'h0000, mdio_oe}, 16'h0000);
		// Undefined opcode to our own address is refused as well
		sta.frame(2'h3, PA, `GTAN_REG_GIG, 16'h0000, smp);
		@(negedge clk_sys);
		chk(smp[16:1], 16'hFFFF);
		chk({15'h0000, mdio_oe}, 16'h0000);
		sta.frame(`GTAN_OP_WRITE, PA ^ 5'h01, `GTAN_REG_GIG, 16'hE000, smp);
		rd(`GTAN_REG_GIG, 16'h0100);
		$display("test foreign address done");
	endtask

	// Reset in mid-run brings register 9 back to its defaults
	task automatic t_rerst();
		wr(`GTAN_REG_GIG, 16'hF800);
		@(posedge clk_sys);
		rstn <= 1'b0;
		repeat (2) @(posedge clk_sys);
		rstn <= 1'b1;
		repeat (2) @(posedge clk_sys);
		rd(`GTAN_REG_GIG, 16'h0300);
		chk(gig_out(), 16'h0300);
		chk({15'h0000, role_pref_master}, 16'h0000);
		$display("test mid-run reset done");
	endtask

	////////////////////////////////////////////////////////////////////////////////
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 40000) begin
			fail_count++;
			results();
		end
	end

	initial begin
		rstn = 1'b0;
		page_rx_valid = 1'b0;
		page_rx_next = 1'b0;
		page_rx_word = 16'h0000;
		role_master = 1'b0;
		repeat (6) @(posedge clk_sys);
		rstn <= 1'b1;
		repeat (2) @(posedge clk_sys);
		t_reset();
		t_gig();
		t_adv();
		t_ro();
		t_page();
		t_role();
		t_badaddr();
		t_rerst();
		results();
	end
endmodule
